// ===== rmc_pkg.sv
// Shared constants and types for the mode-command handler
package rmc_pkg;

  // Command word field positions
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 11;
  localparam int SA_HI = 9;
  localparam int SA_LO = 5;
  localparam int MC_HI = 4;
  localparam int MC_LO = 0;

  // Subaddress values that mark a mode command, and broadcast address
  localparam logic [4:0] SA_MODE_LO = 5'h00;
  localparam logic [4:0] SA_MODE_HI = 5'h1f;
  localparam logic [4:0] BCAST_ADDR = 5'h1f;

  // Mode codes handled here
  localparam logic [4:0] MC_TX_SHUT = 5'h04;
  localparam logic [4:0] MC_TX_OVR = 5'h05;
  localparam logic [4:0] MC_INH_TF = 5'h06;
  localparam logic [4:0] MC_OVR_INH = 5'h07;
  localparam logic [4:0] MC_RESET = 5'h08;
  localparam logic [4:0] MC_RSV_LO = 5'h09;
  localparam logic [4:0] MC_RSV_HI = 5'h0f;
  localparam logic [4:0] MC_VECTOR = 5'h10;
  localparam logic [4:0] MC_SYNC_DW = 5'h11;
  localparam logic [4:0] MC_LAST_CMD = 5'h12;
  localparam logic [4:0] MC_BIT_WORD = 5'h13;
  localparam logic [4:0] MC_SEL_SHUT = 5'h14;
  localparam logic [4:0] MC_SEL_OVR = 5'h15;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_LASTCMD = 8'h08;
  localparam logic [7:0] OFF_BITWORD = 8'h0c;
  localparam logic [7:0] OFF_VECTOR = 8'h10;

  // Control bits and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DUAL_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // Status register field positions
  localparam int STAT_INH_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_TXEN_LO = 8;

  // Handler sequencing states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_DW,
    ST_RESP,
    ST_RST_WAIT
  } rmc_state_t;

endpackage : rmc_pkg

// ===== rmc_txen_cell.sv
`timescale 1ns/1ps
// One transmitter enable flag for one redundant bus
module rmc_txen_cell (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests for this bus
  input wire logic term_rst,
  input wire logic shut,
  input wire logic ovr,
  // Enable state
  output logic en
);

  // Reset re-enables and wins over shutdown; shutdown wins over override
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en <= 1'b1;
    end else if (term_rst) begin
      en <= 1'b1; // [R26]
    end else if (shut) begin
      en <= 1'b0;
    end else if (ovr) begin
      en <= 1'b1;
    end
  end

endmodule : rmc_txen_cell

// ===== rmc_mode_handler.sv
`timescale 1ns/1ps
// Mode-command handler for codes 00100 to 10101 of a remote terminal
// Summary of operation
// R1: Inhibit code forces terminal flag to zero
// R2: Override-inhibit restores live flag, then status
// R3: Reset only after status word finished sending
// R4: Reset accepted addressed or broadcast
// R5: Reserved codes never sent by controller
// R6: Vector code sends status plus vector word
// R7: Vector code never broadcast by controller
// R8: Sync-with-data takes data word, then status
// R9: Last-command code returns previous command bits
// R10: Last-command leaves stored status word unchanged
// R11: BIT code sends status plus BIT word
// R12: Last-command and status codes keep BIT word
// R13: BIT code never broadcast by controller
// R14: BIT word holds own interface faults only
// R15: Selected shutdown disables bus named in data
// R16: Selected override re-enables bus named in data
// R17: Ignore requests aimed at the receiving bus
// R18: Always answer status after transmitter commands
// R19: Dual shutdown disables the other bus
// R20: Dual override re-enables the other bus
// R21: Transmitter commands accepted addressed or broadcast
// R22: Code 10101 is selected override
// R23: Address 31 means broadcast
// R24: Broadcast executes but suppresses status
// R25: Inhibit persists until override or reset
// R26: One enable per bus; reset enables all
module rmc_mode_handler #(
  parameter int NBUS = 4,
  parameter int BUS_W = 2
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Validated words from the decoder
  input wire logic [4:0] own_addr,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  input wire logic [BUS_W-1:0] rx_bus,
  input wire logic dw_valid,
  input wire logic [15:0] dw_word,
  // Own interface hardware test results
  input wire logic bit_load,
  input wire logic [15:0] bit_iface_fault,
  input wire logic term_fault,
  // Response path to the encoder
  output logic rsp_status_req,
  output logic rsp_has_data,
  output logic [15:0] rsp_data,
  input wire logic rsp_done,
  // Effects on the rest of the terminal
  output logic term_flag,
  output logic status_hold,
  output logic rt_reset,
  output logic sync_pulse,
  output logic [15:0] sync_data,
  output logic [NBUS-1:0] tx_enable
);

  rmc_pkg::rmc_state_t state_r;
  logic [1:0] ctrl_r;
  logic inhibit_r;
  logic [15:0] last_cmd_r;
  logic [15:0] bit_word_r;
  logic [15:0] vector_r;
  logic [4:0] pend_mc_r;
  logic [BUS_W-1:0] pend_bus_r;
  logic pend_bcast_r;
  logic [NBUS-1:0] shut_vec;
  logic [NBUS-1:0] ovr_vec;
  logic term_rst;

  // Command decode
  logic [4:0] c_addr;
  logic [4:0] c_sa;
  logic [4:0] c_mc;
  logic c_bcast;
  logic c_mine;
  logic c_mode;
  logic c_take;
  assign c_addr = cmd_word[rmc_pkg::ADDR_HI:rmc_pkg::ADDR_LO];
  assign c_sa = cmd_word[rmc_pkg::SA_HI:rmc_pkg::SA_LO];
  assign c_mc = cmd_word[rmc_pkg::MC_HI:rmc_pkg::MC_LO];
  assign c_bcast = (c_addr == rmc_pkg::BCAST_ADDR); // [R23]
  assign c_mine = c_bcast || (c_addr == own_addr);
  assign c_mode = (c_sa == rmc_pkg::SA_MODE_LO) ||
                  (c_sa == rmc_pkg::SA_MODE_HI);
  assign c_take = cmd_valid && c_mine && ctrl_r[rmc_pkg::CTRL_EN_BIT]
                  && (state_r == rmc_pkg::ST_IDLE);

  // Codes sent back with a data word must be individually addressed
  logic c_tx_dw;
  assign c_tx_dw = (c_mc == rmc_pkg::MC_VECTOR) ||
                   (c_mc == rmc_pkg::MC_LAST_CMD) ||
                   (c_mc == rmc_pkg::MC_BIT_WORD);

  // Code is one this block acts on
  logic c_known;
  always_comb begin
    c_known = 1'b0;
    case (c_mc)
      rmc_pkg::MC_TX_SHUT,
      rmc_pkg::MC_TX_OVR: c_known = ctrl_r[rmc_pkg::CTRL_DUAL_BIT];
      rmc_pkg::MC_INH_TF,
      rmc_pkg::MC_OVR_INH,
      rmc_pkg::MC_RESET,
      rmc_pkg::MC_SYNC_DW,
      rmc_pkg::MC_SEL_SHUT,
      rmc_pkg::MC_SEL_OVR: c_known = 1'b1; // [R4] [R21] [R22]
      rmc_pkg::MC_VECTOR,
      rmc_pkg::MC_LAST_CMD,
      rmc_pkg::MC_BIT_WORD: c_known = !c_bcast; // [R7] [R13]
      default: c_known = 1'b0; // Reserved codes are not acted on [R5]
    endcase
  end

  logic c_act;
  logic c_needs_dw;
  assign c_act = c_take && c_mode && c_known;
  assign c_needs_dw = (c_mc == rmc_pkg::MC_SYNC_DW) ||
                      (c_mc == rmc_pkg::MC_SEL_SHUT) ||
                      (c_mc == rmc_pkg::MC_SEL_OVR);

  // Commands that finish now, and commands finishing on their data word
  logic now_go;
  logic dw_go;
  logic go;
  logic [4:0] go_mc;
  logic go_bcast;
  logic [BUS_W-1:0] go_bus;
  assign now_go = c_act && !c_needs_dw;
  assign dw_go = (state_r == rmc_pkg::ST_WAIT_DW) && dw_valid;
  assign go = now_go || dw_go;
  assign go_mc = dw_go ? pend_mc_r : c_mc;
  assign go_bcast = dw_go ? pend_bcast_r : c_bcast;
  assign go_bus = dw_go ? pend_bus_r : rx_bus;

  // Sequencing of each accepted mode command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= rmc_pkg::ST_IDLE;
    end else begin
      case (state_r)
        rmc_pkg::ST_IDLE: begin
          if (c_act && c_needs_dw) begin
            state_r <= rmc_pkg::ST_WAIT_DW; // [R8]
          end else if (now_go && c_bcast && c_mc == rmc_pkg::MC_RESET) begin
            state_r <= rmc_pkg::ST_IDLE;
          end else if (now_go && !c_bcast) begin
            state_r <= (c_mc == rmc_pkg::MC_RESET) ?
                       rmc_pkg::ST_RST_WAIT : rmc_pkg::ST_RESP;
          end
        end
        rmc_pkg::ST_WAIT_DW: begin
          // A new command aborts a message whose data word never came
          if (dw_valid) begin
            state_r <= pend_bcast_r ? rmc_pkg::ST_IDLE : rmc_pkg::ST_RESP;
          end else if (cmd_valid) begin
            state_r <= rmc_pkg::ST_IDLE;
          end
        end
        rmc_pkg::ST_RESP: begin
          if (rsp_done) begin
            state_r <= rmc_pkg::ST_IDLE;
          end
        end
        rmc_pkg::ST_RST_WAIT: begin
          if (rsp_done) begin
            state_r <= rmc_pkg::ST_IDLE; // [R3]
          end
        end
        default: state_r <= rmc_pkg::ST_IDLE;
      endcase
    end
  end

  // Context held while the data word is awaited
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_mc_r <= 5'h00;
      pend_bus_r <= '0;
      pend_bcast_r <= 1'b0;
    end else if (c_act && c_needs_dw) begin
      pend_mc_r <= c_mc;
      pend_bus_r <= rx_bus;
      pend_bcast_r <= c_bcast;
    end
  end

  // Terminal reset: broadcast at once, addressed after the status word
  assign term_rst = (now_go && c_bcast && c_mc == rmc_pkg::MC_RESET) ||
                    (state_r == rmc_pkg::ST_RST_WAIT && rsp_done); // [R3]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rt_reset <= 1'b0;
    end else begin
      rt_reset <= term_rst; // [R4]
    end
  end

  // Response request; broadcast never answers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_status_req <= 1'b0;
      rsp_has_data <= 1'b0;
      rsp_data <= rmc_pkg::WORD_RST;
    end else begin
      rsp_status_req <= go && !go_bcast; // [R2] [R18] [R24]
      if (go && !go_bcast) begin
        rsp_has_data <= 1'b0;
        case (go_mc)
          rmc_pkg::MC_VECTOR: begin
            rsp_has_data <= 1'b1;
            rsp_data <= vector_r; // [R6]
          end
          rmc_pkg::MC_LAST_CMD: begin
            rsp_has_data <= 1'b1;
            rsp_data <= last_cmd_r; // [R9]
          end
          rmc_pkg::MC_BIT_WORD: begin
            rsp_has_data <= 1'b1;
            rsp_data <= bit_word_r; // [R11]
          end
          default: rsp_data <= rsp_data;
        endcase
      end else if (rsp_done) begin
        rsp_has_data <= 1'b0;
      end
    end
  end

  // Last command excludes the last-command code itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_cmd_r <= rmc_pkg::WORD_RST;
    end else if (term_rst) begin
      last_cmd_r <= rmc_pkg::WORD_RST;
    end else if (c_take &&
                 !(c_mode && c_mc == rmc_pkg::MC_LAST_CMD)) begin
      last_cmd_r <= cmd_word; // [R9]
    end
  end

  // Freeze the status word while the last command is reported
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_hold <= 1'b0;
    end else if (now_go && c_mc == rmc_pkg::MC_LAST_CMD) begin
      status_hold <= 1'b1; // [R10]
    end else if (rsp_done) begin
      status_hold <= 1'b0;
    end
  end

  // Only interface-hardware results load; no command touches it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_word_r <= rmc_pkg::WORD_RST;
    end else if (bit_load) begin
      bit_word_r <= bit_iface_fault; // [R12] [R14]
    end
  end

  // Inhibit flag persists across messages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inhibit_r <= 1'b0;
    end else if (term_rst) begin
      inhibit_r <= 1'b0; // [R25]
    end else if (go && go_mc == rmc_pkg::MC_INH_TF) begin
      inhibit_r <= 1'b1; // [R1]
    end else if (go && go_mc == rmc_pkg::MC_OVR_INH) begin
      inhibit_r <= 1'b0; // [R2]
    end
  end

  // Registered flag so the status word sees a clean level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_flag <= 1'b0;
    end else begin
      term_flag <= term_fault && !inhibit_r; // [R1] [R2]
    end
  end

  // Synchronize with data word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_pulse <= 1'b0;
      sync_data <= rmc_pkg::WORD_RST;
    end else begin
      sync_pulse <= dw_go && pend_mc_r == rmc_pkg::MC_SYNC_DW;
      if (dw_go && pend_mc_r == rmc_pkg::MC_SYNC_DW) begin
        sync_data <= dw_word; // [R8]
      end
    end
  end

  // Target bus: partner bus for the dual codes, else the data word names it
  logic [BUS_W-1:0] tgt_bus;
  logic tgt_ok;
  assign tgt_bus = dw_go ? dw_word[BUS_W-1:0] :
                   (go_bus ^ {{(BUS_W-1){1'b0}}, 1'b1}); // [R19] [R20]
  assign tgt_ok = (tgt_bus != go_bus); // [R17]

  logic do_shut;
  logic do_ovr;
  assign do_shut = go && tgt_ok && (go_mc == rmc_pkg::MC_TX_SHUT ||
                   go_mc == rmc_pkg::MC_SEL_SHUT); // [R15] [R19]
  assign do_ovr = go && tgt_ok && (go_mc == rmc_pkg::MC_TX_OVR ||
                  go_mc == rmc_pkg::MC_SEL_OVR); // [R16] [R20] [R22]

  // One enable flag per bus
  genvar gi;
  generate
    for (gi = 0; gi < NBUS; gi++) begin : g_txen
      assign shut_vec[gi] = do_shut && (tgt_bus == BUS_W'(gi));
      assign ovr_vec[gi] = do_ovr && (tgt_bus == BUS_W'(gi));
      rmc_txen_cell u_cell (
        .pclk(pclk),
        .presetn(presetn),
        .term_rst(term_rst),
        .shut(shut_vec[gi]),
        .ovr(ovr_vec[gi]),
        .en(tx_enable[gi])
      ); // [R26]
    end
  endgenerate

  // APB slave: zero wait, error on unmapped offsets
  logic apb_wr;
  logic hit;
  assign apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  always_comb begin
    hit = 1'b1;
    prdata = 32'h0000_0000;
    case (paddr)
      rmc_pkg::OFF_CTRL: prdata = {30'h0, ctrl_r};
      rmc_pkg::OFF_STAT: begin
        prdata[rmc_pkg::STAT_INH_BIT] = inhibit_r;
        prdata[rmc_pkg::STAT_BUSY_BIT] = (state_r != rmc_pkg::ST_IDLE);
        prdata[rmc_pkg::STAT_TXEN_LO +: NBUS] = tx_enable;
      end
      rmc_pkg::OFF_LASTCMD: prdata = {16'h0, last_cmd_r};
      rmc_pkg::OFF_BITWORD: prdata = {16'h0, bit_word_r};
      rmc_pkg::OFF_VECTOR: prdata = {16'h0, vector_r};
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !hit;

  // Software-writable control and service vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= rmc_pkg::CTRL_RST;
      vector_r <= rmc_pkg::WORD_RST;
    end else if (apb_wr && paddr == rmc_pkg::OFF_CTRL) begin
      ctrl_r <= pwdata[1:0];
    end else if (apb_wr && paddr == rmc_pkg::OFF_VECTOR) begin
      vector_r <= pwdata[15:0];
    end
  end

endmodule : rmc_mode_handler

// ===== rmc_mode_handler_assertions.sv
`timescale 1ns/1ps
// Port checks bound to the mode-command handler
module rmc_mode_handler_assertions #(
  parameter int NBUS = 4,
  parameter int BUS_W = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Received words
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  input wire logic [BUS_W-1:0] rx_bus,
  input wire logic dw_valid,
  input wire logic [15:0] dw_word,
  input wire logic term_fault,
  // Response and effects
  input wire logic rsp_status_req,
  input wire logic rsp_has_data,
  input wire logic [15:0] rsp_data,
  input wire logic rsp_done,
  input wire logic term_flag,
  input wire logic status_hold,
  input wire logic rt_reset,
  input wire logic sync_pulse,
  input wire logic [15:0] sync_data,
  input wire logic [NBUS-1:0] tx_enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Broadcast command on the wire
  logic bc_cmd;
  assign bc_cmd = cmd_valid && cmd_word[15:11] == 5'h1f;

  property p_flag;
    term_flag |-> $past(term_fault);
  endproperty
  a_flag: assert property (p_flag)
    else $error("flag set with no fault");

  property p_rst_late;
    $rose(rt_reset) |-> $past(rsp_done) || $past(bc_cmd)
      || $past(bc_cmd, 2);
  endproperty
  a_rst_late: assert property (p_rst_late)
    else $error("reset before status sent");

  property p_rst_en;
    rt_reset |-> ##[0:1] &tx_enable;
  endproperty
  a_rst_en: assert property (p_rst_en)
    else $error("reset left a transmitter off");

  property p_quiet;
    bc_cmd |=> !rsp_status_req;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("status after broadcast");

  property p_data;
    rsp_has_data && !rsp_done |=> rsp_has_data && $stable(rsp_data);
  endproperty
  a_data: assert property (p_data)
    else $error("response word dropped early");

  property p_hold;
    status_hold && !rsp_done |=> status_hold;
  endproperty
  a_hold: assert property (p_hold)
    else $error("status hold dropped early");

  property p_sync;
    sync_pulse |-> $past(dw_valid) && sync_data == $past(dw_word);
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync data not the data word");

  property p_own;
    $stable(rx_bus) && !rt_reset |-> !$fell(tx_enable[rx_bus]);
  endproperty
  a_own: assert property (p_own)
    else $error("receiving bus shut down");
endmodule : rmc_mode_handler_assertions

bind rmc_mode_handler rmc_mode_handler_assertions
  #(.NBUS(NBUS), .BUS_W(BUS_W)) u_chk (
  .pclk(pclk),
  .presetn(presetn),
  .cmd_valid(cmd_valid),
  .cmd_word(cmd_word),
  .rx_bus(rx_bus),
  .dw_valid(dw_valid),
  .dw_word(dw_word),
  .term_fault(term_fault),
  .rsp_status_req(rsp_status_req),
  .rsp_has_data(rsp_has_data),
  .rsp_data(rsp_data),
  .rsp_done(rsp_done),
  .term_flag(term_flag),
  .status_hold(status_hold),
  .rt_reset(rt_reset),
  .sync_pulse(sync_pulse),
  .sync_data(sync_data),
  .tx_enable(tx_enable)
);

// ===== rmc_bc_model.sv
`timescale 1ns/1ps
// Far-side encoder and controller: ends each response after a delay
module rmc_bc_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Response path
  input wire logic rsp_status_req,
  input wire logic [3:0] dly,
  output logic rsp_done
);
  int cnt;
  // Slow answers keep the handler busy longer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      rsp_done <= 1'b0;
    end else begin
      rsp_done <= cnt == 1;
      if (rsp_status_req) cnt <= int'(dly) + 2;
      else if (cnt > 0) cnt <= cnt - 1;
    end
  end
endmodule : rmc_bc_model

// ===== tb.sv
`timescale 1ns/1ps
// Self-checking bench for the mode-command handler
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] own_addr;
  logic cmd_valid, dw_valid, bit_load, term_fault, rsp_done;
  logic [15:0] cmd_word, dw_word, bit_iface_fault, rsp_data, sync_data;
  logic [15:0] rdat;
  logic [1:0] rx_bus;
  logic rsp_status_req, rsp_has_data, term_flag, status_hold;
  logic rt_reset, sync_pulse, seen, hd, sh, sp, dn, early;
  logic [3:0] tx_enable, dly;
  int n_mismatch, samples_checked;

  rmc_mode_handler #(.NBUS(4), .BUS_W(2)) uut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .own_addr(own_addr),
    .cmd_valid(cmd_valid),
    .cmd_word(cmd_word),
    .rx_bus(rx_bus),
    .dw_valid(dw_valid),
    .dw_word(dw_word),
    .bit_load(bit_load),
    .bit_iface_fault(bit_iface_fault),
    .term_fault(term_fault),
    .rsp_status_req(rsp_status_req),
    .rsp_has_data(rsp_has_data),
    .rsp_data(rsp_data),
    .rsp_done(rsp_done),
    .term_flag(term_flag),
    .status_hold(status_hold),
    .rt_reset(rt_reset),
    .sync_pulse(sync_pulse),
    .sync_data(sync_data),
    .tx_enable(tx_enable)
  );
  rmc_bc_model u_bc (.pclk(pclk), .presetn(presetn),
    .rsp_status_req(rsp_status_req), .dly(dly), .rsp_done(rsp_done));

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] e, s);
    samples_checked++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      n_mismatch++;
    end
  endtask : chk

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // One APB transfer, request held until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    repeat (9) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) begin
      n_mismatch++;
      results();
    end
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask : apb

  // Mode command, optional data word, then wait out the response
  task automatic msg(input logic [4:0] a, mc, input logic d,
                     input logic [15:0] w, input logic st);
    {seen, dn, early} = 3'b000;
    // Transmit codes carry T/R; sent addressed only
    cmd_word <= {a, (mc == 5'h10 || mc == 5'h12 || mc == 5'h13), 5'h00, mc};
    cmd_valid <= 1'b1;
    @(posedge pclk);
    cmd_valid <= 1'b0;
    if (d) begin
      {dw_word, dw_valid} <= {w, 1'b1};
      @(posedge pclk);
      dw_valid <= 1'b0;
    end
    repeat (8) if (!seen) begin
      #1 seen = rsp_status_req;
      {hd, sh, sp, rdat} = {rsp_has_data, status_hold, sync_pulse, rsp_data};
      @(posedge pclk);
    end
    chk("status", st, seen);
    if (seen) begin
      repeat (40) if (!dn) begin
        #1 dn = rsp_done;
        early |= rt_reset;
        @(posedge pclk);
      end
      if (!dn) begin
        n_mismatch++;
        results();
      end
    end
  endtask : msg

  task automatic t_regs;
    apb(0, 8'h00, 0);
    chk("ctrl", 32'h3, rd);
    apb(0, 8'h04, 0);
    chk("stat", 32'h0f00, rd);
    apb(1, 8'h10, 32'h1234);
    apb(1, 8'h44, 32'h1);
    chk("slverr", 1, er);
    // Dual codes refused with dual mode off, all refused when disabled
    apb(1, 8'h00, 32'h1);
    msg(5'h05, 5'h04, 0, 0, 0);
    chk("txen", 4'hf, tx_enable);
    apb(1, 8'h00, 32'h0);
    msg(5'h05, 5'h06, 0, 0, 0);
    apb(0, 8'h04, 0);
    chk("stat", 32'h0f00, rd);
    apb(1, 8'h00, 32'h3);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_flag;
    term_fault <= 1'b1;
    msg(5'h1f, 5'h06, 0, 0, 0);
    chk("flag", 0, term_flag);
    apb(0, 8'h04, 0);
    chk("stat", 32'h0f01, rd);
    msg(5'h05, 5'h12, 0, 0, 1);
    chk("flag", 0, term_flag);
    msg(5'h05, 5'h07, 0, 0, 1);
    chk("flag", 1, term_flag);
    $display("t_flag done");
  endtask : t_flag

  task automatic t_last;
    {bit_iface_fault, bit_load} <= {16'h00a5, 1'b1};
    @(posedge pclk);
    bit_load <= 1'b0;
    msg(5'h05, 5'h13, 0, 0, 1);
    chk("bit", 16'h00a5, rdat);
    msg(5'h05, 5'h12, 0, 0, 1);
    chk("last", {5'h05, 1'b1, 5'h00, 5'h13}, rdat);
    chk("hold", 1, sh);
    msg(5'h05, 5'h12, 0, 0, 1);
    chk("last", {5'h05, 1'b1, 5'h00, 5'h13}, rdat);
    msg(5'h05, 5'h13, 0, 0, 1);
    chk("bit", 16'h00a5, rdat);
    $display("t_last done");
  endtask : t_last

  task automatic t_vec;
    msg(5'h05, 5'h10, 0, 0, 1);
    chk("vec", 17'h11234, {hd, rdat});
    msg(5'h05, 5'h11, 1, 16'habcd, 1);
    chk("sync", 16'habcd, sync_data);
    chk("sync_pulse", 1, sp);
    $display("t_vec done");
  endtask : t_vec

  // Slow far side here; receiving bus is 0
  task automatic t_tx;
    dly <= 4'h6;
    msg(5'h05, 5'h14, 1, 16'h0002, 1);
    chk("txen", 4'hb, tx_enable);
    chk("sync_pulse", 0, sp);
    msg(5'h05, 5'h14, 1, 16'h0000, 1);
    chk("txen", 4'hb, tx_enable);
    msg(5'h1f, 5'h14, 1, 16'h0003, 0);
    chk("txen", 4'h3, tx_enable);
    msg(5'h05, 5'h15, 1, 16'h0002, 1);
    chk("txen", 4'h7, tx_enable);
    msg(5'h05, 5'h04, 0, 0, 1);
    chk("txen", 4'h5, tx_enable);
    msg(5'h05, 5'h05, 0, 0, 1);
    chk("txen", 4'h7, tx_enable);
    $display("t_tx done");
  endtask : t_tx

  task automatic t_rst;
    dly <= 4'h0;
    msg(5'h05, 5'h06, 0, 0, 1);
    msg(5'h05, 5'h08, 0, 0, 1);
    chk("early", 0, early);
    #1 chk("rst", 1, rt_reset);
    @(posedge pclk);
    @(posedge pclk);
    chk("txen", 4'hf, tx_enable);
    chk("flag", 1, term_flag);
    msg(5'h1f, 5'h14, 1, 16'h0003, 0);
    msg(5'h1f, 5'h08, 0, 0, 0);
    chk("txen", 4'hf, tx_enable);
    $display("t_rst done");
  endtask : t_rst

  // Reset, then each scenario; reserved codes never sent
  initial begin
    {presetn, psel, penable, pwrite, cmd_valid, dw_valid} = '0;
    {bit_load, term_fault, paddr, pwdata} = '0;
    {cmd_word, dw_word, bit_iface_fault} = '0;
    {own_addr, rx_bus, dly} = {5'h05, 2'h0, 4'h0};
    n_mismatch = 0;
    samples_checked = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_flag();
    t_last();
    t_vec();
    t_tx();
    t_rst();
    results();
  end
endmodule : tb
